// [logic/bdio_pkg.sv]
`default_nettype none

package bdio_pkg;

    // ----------------------------------------------------------------
    // Bus addressing and register layout
    // ----------------------------------------------------------------
    localparam logic [6:0] DEV_ADDR = 7'h20;
    localparam logic [7:0] PORT_RESET = 8'hFF;
    localparam logic [7:0] CTRL_RESET = 8'hF0;
    localparam int FIXED_LSB = 0;
    localparam int CONFIG_LSB = 4;
    localparam int STROBE_BIT = 1;
    localparam int DIR_LO_BIT = 2;
    localparam int DIR_HI_BIT = 3;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [1:0] DIR_RESET = 2'h0;
    localparam logic [3:0] HOLD_RESET = 4'h0;

    // ----------------------------------------------------------------
    // Pin sampling
    // ----------------------------------------------------------------
    localparam logic [1:0] BUS_IDLE = 2'h3;
    localparam logic [3:0] FIXED_IDLE = 4'h0;
    localparam logic [3:0] CONFIG_IDLE = 4'hF;
    localparam logic [3:0] HOST_IDLE = 4'h0;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_AACK,
        ST_WDATA,
        ST_WACK,
        ST_RDATA,
        ST_RACK
    } bdio_slv_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] data;
    } bdio_bus_evt_t;

endpackage

`default_nettype wire

// [logic/bdio_sync.sv]
`default_nettype none

// ----------------------------------------------------------------
// Three-stage sampler, change taken when stages two and three agree
// ----------------------------------------------------------------
module bdio_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] stable_o
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clock_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    stage1[i] <= INIT[i];
                    stage2[i] <= INIT[i];
                    stage3[i] <= INIT[i];
                    stable_o[i] <= INIT[i];
                end else if (ce_i) begin
                    stage1[i] <= async_i[i];
                    stage2[i] <= stage1[i];
                    stage3[i] <= stage2[i];
                    // Single-cycle glitches never reach the logic
                    if (stage2[i] == stage3[i]) begin
                        stable_o[i] <= stage3[i];
                    end
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// [logic/bdio_port_top.sv]
// Operation
// - Index-free read: fixed inputs in bits 0-3
// - Fixed inputs weakly pulled low
// - Open-drain outputs latch host lines a-d on commit
// - Pins 1-2 and 3-4 share direction
// - Configurable output only sinks, never drives
// - Both expanders answer address 0x20
// - Configurable pins 1-4 on bits 4-7
// - Alert goes low on fresh input data
// - Low group read, high group written
// - High group read, low group written
// - All outputs: bits 4-7 set pins
// - Direction commits on strobe rising edge
`default_nettype none

// ----------------------------------------------------------------
// Byte-wide two-wire slave without register index
// ----------------------------------------------------------------
module bdio_i2c_slave (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [7:0] rd_data_i,
    output bdio_pkg::bdio_bus_evt_t evt_o,
    output logic sda_o,
    output logic sda_oe_n_o
);

    logic [1:0] line;
    logic scl_d;
    logic sda_d;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [3:0] bit_cnt;
    logic rw;
    logic acked;
    logic hold_low;
    bdio_pkg::bdio_slv_state_t state;

    bdio_sync #(
        .WIDTH(2),
        .INIT(bdio_pkg::BUS_IDLE)
    ) u_sync (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .async_i({scl_i, sda_i}),
        .stable_o(line)
    );

    // ----------------------------------------------------------------
    // Bus conditions
    // ----------------------------------------------------------------
    wire scl = line[1];
    wire sda = line[0];
    wire scl_rise = scl & ~scl_d;
    wire scl_fall = ~scl & scl_d;
    wire start_seen = scl & scl_d & sda_d & ~sda;
    wire stop_seen = scl & scl_d & ~sda_d & sda;
    wire byte_done = (bit_cnt == bdio_pkg::BYTE_BITS);
    wire addr_hit = (shreg[7:1] == bdio_pkg::DEV_ADDR);

    // Line is only ever pulled low, never driven high
    assign sda_o = 1'b0;
    assign sda_oe_n_o = ~hold_low;

    // ----------------------------------------------------------------
    // Transfer sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= bdio_pkg::ST_IDLE;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            shreg <= 8'h00;
            tx <= 8'h00;
            bit_cnt <= 4'h0;
            rw <= 1'b0;
            acked <= 1'b0;
            hold_low <= 1'b0;
            evt_o <= '0;
        end else if (ce_i) begin
            scl_d <= scl;
            sda_d <= sda;
            evt_o.wr <= 1'b0;
            evt_o.rd <= 1'b0;
            if (stop_seen) begin
                state <= bdio_pkg::ST_IDLE;
                hold_low <= 1'b0;
            end else if (start_seen) begin
                state <= bdio_pkg::ST_ADDR;
                bit_cnt <= 4'h0;
                hold_low <= 1'b0;
            end else if (scl_rise) begin
                shreg <= {shreg[6:0], sda};
                bit_cnt <= bit_cnt + 4'h1;
                if (state == bdio_pkg::ST_RACK) begin
                    acked <= ~sda;
                end
            end else if (scl_fall) begin
                unique case (state)
                    bdio_pkg::ST_IDLE: begin
                    end
                    bdio_pkg::ST_ADDR: begin
                        if (byte_done) begin
                            if (addr_hit) begin
                                state <= bdio_pkg::ST_AACK;
                                hold_low <= 1'b1;
                                rw <= shreg[0];
                            end else begin
                                state <= bdio_pkg::ST_IDLE;
                            end
                        end
                    end
                    bdio_pkg::ST_AACK: begin
                        bit_cnt <= 4'h0;
                        if (rw) begin
                            // Port is sampled at the start of each byte
                            state <= bdio_pkg::ST_RDATA;
                            tx <= {rd_data_i[6:0], 1'b0};
                            hold_low <= ~rd_data_i[7];
                            evt_o.rd <= 1'b1;
                        end else begin
                            state <= bdio_pkg::ST_WDATA;
                            hold_low <= 1'b0;
                        end
                    end
                    bdio_pkg::ST_WDATA: begin
                        if (byte_done) begin
                            state <= bdio_pkg::ST_WACK;
                            hold_low <= 1'b1;
                            evt_o.wr <= 1'b1;
                            evt_o.data <= shreg;
                        end
                    end
                    bdio_pkg::ST_WACK: begin
                        state <= bdio_pkg::ST_WDATA;
                        bit_cnt <= 4'h0;
                        hold_low <= 1'b0;
                    end
                    bdio_pkg::ST_RDATA: begin
                        if (byte_done) begin
                            state <= bdio_pkg::ST_RACK;
                            hold_low <= 1'b0;
                        end else begin
                            hold_low <= ~tx[7];
                            tx <= {tx[6:0], 1'b0};
                        end
                    end
                    bdio_pkg::ST_RACK: begin
                        bit_cnt <= 4'h0;
                        if (acked) begin
                            state <= bdio_pkg::ST_RDATA;
                            tx <= {rd_data_i[6:0], 1'b0};
                            hold_low <= ~rd_data_i[7];
                            evt_o.rd <= 1'b1;
                        end else begin
                            state <= bdio_pkg::ST_IDLE;
                            hold_low <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end

endmodule

// ----------------------------------------------------------------
// Digital I/O port: fixed inputs, configurable pins, open-drain outs
// ----------------------------------------------------------------
module bdio_port_top (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic pri_scl_i,
    input wire logic pri_sda_i,
    output logic pri_sda_o,
    output logic pri_sda_oe_n_o,
    input wire logic sec_scl_i,
    input wire logic sec_sda_i,
    output logic sec_sda_o,
    output logic sec_sda_oe_n_o,
    input wire logic [3:0] input_pin_i,
    output logic [3:0] input_pulldown_o,
    input wire logic [3:0] config_pin_i,
    output logic [3:0] config_pin_o,
    output logic [3:0] config_pin_oe_n_o,
    input wire logic [3:0] host_line_i,
    output logic [3:0] output_pin_o,
    output logic [3:0] output_pin_oe_n_o,
    output logic alert_o,
    output logic alert_oe_n_o
);

    bdio_pkg::bdio_bus_evt_t pri_evt;
    bdio_pkg::bdio_bus_evt_t sec_evt;
    logic [11:0] pins;
    logic [7:0] port_latch;
    logic [7:0] ctrl;
    logic [1:0] dir_out;
    logic [3:0] out_hold;
    logic [7:0] snap;
    logic alert_flag;

    // ----------------------------------------------------------------
    // Pin sampling
    // ----------------------------------------------------------------
    bdio_sync #(
        .WIDTH(12),
        .INIT({bdio_pkg::HOST_IDLE, bdio_pkg::CONFIG_IDLE,
               bdio_pkg::FIXED_IDLE})
    ) u_pins (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .async_i({host_line_i, config_pin_i, input_pin_i}),
        .stable_o(pins)
    );

    wire [3:0] fixed_lvl = pins[3:0];
    wire [3:0] cfg_lvl = pins[7:4];
    wire [3:0] host_lvl = pins[11:8];

    // ----------------------------------------------------------------
    // Two expanders, same address, separate buses
    // ----------------------------------------------------------------
    wire [7:0] pin_levels = {cfg_lvl, fixed_lvl};

    bdio_i2c_slave u_primary (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .scl_i(pri_scl_i),
        .sda_i(pri_sda_i),
        .rd_data_i(pin_levels),
        .evt_o(pri_evt),
        .sda_o(pri_sda_o),
        .sda_oe_n_o(pri_sda_oe_n_o)
    );

    // Controller reads back its own last written value
    bdio_i2c_slave u_controller (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .scl_i(sec_scl_i),
        .sda_i(sec_sda_i),
        .rd_data_i(ctrl),
        .evt_o(sec_evt),
        .sda_o(sec_sda_o),
        .sda_oe_n_o(sec_sda_oe_n_o)
    );

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire commit = sec_evt.wr & sec_evt.data[bdio_pkg::STROBE_BIT]
                  & ~ctrl[bdio_pkg::STROBE_BIT];
    wire [1:0] next_dir = {sec_evt.data[bdio_pkg::DIR_HI_BIT],
                           sec_evt.data[bdio_pkg::DIR_LO_BIT]};
    wire [3:0] cfg_is_out = {{2{dir_out[1]}}, {2{dir_out[0]}}};
    wire [3:0] cfg_latch = port_latch[bdio_pkg::CONFIG_LSB +: 4];
    wire [3:0] next_cfg_sink = cfg_is_out & ~cfg_latch;
    wire [7:0] watch_mask = {~cfg_is_out, 4'hF};
    wire fresh = |((pin_levels ^ snap) & watch_mask);
    wire alert_clear = pri_evt.rd | pri_evt.wr;

    assign input_pulldown_o = 4'hF;
    assign config_pin_o = 4'h0;
    assign output_pin_o = 4'h0;
    assign alert_o = 1'b0;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            port_latch <= bdio_pkg::PORT_RESET;
            ctrl <= bdio_pkg::CTRL_RESET;
        end else if (ce_i) begin
            if (pri_evt.wr) begin
                port_latch <= pri_evt.data;
            end
            if (sec_evt.wr) begin
                ctrl <= sec_evt.data;
            end
        end
    end

    // Direction and outputs move only on the commit edge
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dir_out <= bdio_pkg::DIR_RESET;
            out_hold <= bdio_pkg::HOLD_RESET;
        end else if (ce_i && commit) begin
            dir_out <= next_dir;
            out_hold <= host_lvl;
        end
    end

    // Drivers registered so pads never see decode glitches
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            config_pin_oe_n_o <= 4'hF;
            output_pin_oe_n_o <= 4'hF;
        end else if (ce_i) begin
            config_pin_oe_n_o <= ~next_cfg_sink;
            output_pin_oe_n_o <= ~out_hold;
        end
    end

    // ----------------------------------------------------------------
    // New-data alert, set wins over clear
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            snap <= {bdio_pkg::CONFIG_IDLE, bdio_pkg::FIXED_IDLE};
            alert_flag <= 1'b0;
        end else if (ce_i) begin
            snap <= pin_levels;
            if (fresh) begin
                alert_flag <= 1'b1;
            end else if (alert_clear) begin
                alert_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            alert_oe_n_o <= 1'b1;
        end else if (ce_i) begin
            alert_oe_n_o <= ~alert_flag;
        end
    end

endmodule

`default_nettype wire

// [testbench/bdio_port_chk.sv]
`default_nettype none

module bdio_port_chk (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic pri_scl_i,
    input wire logic sec_scl_i,
    input wire logic pri_sda_oe_n_o,
    input wire logic sec_sda_oe_n_o,
    input wire logic [3:0] input_pin_i,
    input wire logic [3:0] input_pulldown_o,
    input wire logic [3:0] config_pin_i,
    input wire logic [3:0] config_pin_o,
    input wire logic [3:0] config_pin_oe_n_o,
    input wire logic [3:0] output_pin_o,
    input wire logic [3:0] output_pin_oe_n_o,
    input wire logic alert_o,
    input wire logic alert_oe_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);

    // ------------------------------------------------
    // Quiet time since any input or commit activity
    // ------------------------------------------------
    logic [3:0] quiet;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            quiet <= 4'h0;
        end else if ($changed(input_pin_i) || $changed(config_pin_i)
                     || $changed(sec_scl_i)) begin
            quiet <= 4'h0;
        end else if (quiet != 4'hF) begin
            quiet <= quiet + 4'h1;
        end
    end

    // ------------------------------------------------
    // Assertions
    // ------------------------------------------------
    sink_only_a:
        assert property (config_pin_o == 4'h0 && output_pin_o == 4'h0
                         && alert_o == 1'h0)
        else $error("open-drain pin driven high");
    pulldown_on_a:
        assert property (input_pulldown_o == 4'hF)
        else $error("fixed input pulldown off");
    pri_ack_a:
        assert property ($changed(pri_sda_oe_n_o) |-> !pri_scl_i)
        else $error("primary data moved while clock high");
    sec_ack_a:
        assert property ($changed(sec_sda_oe_n_o) |-> !sec_scl_i)
        else $error("controller data moved while clock high");
    out_commit_a:
        assert property ($changed(output_pin_oe_n_o) |-> !sec_scl_i)
        else $error("output changed outside a controller write");
    dir_change_a:
        assert property ($changed(config_pin_oe_n_o)
                         |-> !pri_scl_i || !sec_scl_i)
        else $error("pin sink changed without a write");
    alert_quiet_a:
        assert property (quiet > 4'hC && alert_oe_n_o |=> alert_oe_n_o)
        else $error("alert without fresh input");
    alert_set_a:
        assert property (($changed(input_pin_i) && pri_scl_i)
                         ##1 (pri_scl_i && $stable(input_pin_i))[*8]
                         |-> !alert_oe_n_o)
        else $error("alert missing after input change");

    alert_cov: cover property ($fell(alert_oe_n_o));
    commit_cov: cover property ($changed(output_pin_oe_n_o));
    sink_cov: cover property ($fell(config_pin_oe_n_o[2]));
endmodule

bind bdio_port_top bdio_port_chk i_chk (
    .clock_i(clock_i), .resetn_i(resetn_i), .pri_scl_i(pri_scl_i),
    .sec_scl_i(sec_scl_i), .pri_sda_oe_n_o(pri_sda_oe_n_o),
    .sec_sda_oe_n_o(sec_sda_oe_n_o), .input_pin_i(input_pin_i),
    .input_pulldown_o(input_pulldown_o), .config_pin_i(config_pin_i),
    .config_pin_o(config_pin_o), .config_pin_oe_n_o(config_pin_oe_n_o),
    .output_pin_o(output_pin_o), .output_pin_oe_n_o(output_pin_oe_n_o),
    .alert_o(alert_o), .alert_oe_n_o(alert_oe_n_o)
);

`default_nettype wire

// [testbench/bdio_host.sv]
`default_nettype none

module bdio_host (
    input wire logic clock_i,
    input wire logic [1:0] sda_i,
    output logic [1:0] scl_o,
    output logic [1:0] sda_o,
    output logic [3:0] host_line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------
    // Bus master, all changes on the falling clock
    // ------------------------------------------------
    localparam int HALF = 10;
    logic [7:0] ctrl_base = 8'hF0;
    logic [1:0] cfg = 2'h0;
    initial begin
        scl_o = 2'h3;
        sda_o = 2'h3;
        host_line_o = 4'h0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clock_i);
    endtask

    // Data moves a few clocks after the clock falls, so the slave's
    // filter never sees data and clock change together
    task automatic put_bit(input int b, input logic v, output logic s);
        tick(4);
        sda_o[b] = v;
        tick(HALF);
        scl_o[b] = 1'h1;
        tick(HALF);
        s = sda_i[b];
        scl_o[b] = 1'h0;
    endtask

    task automatic byte_io(input int b, input logic [7:0] tx,
                           output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            put_bit(b, tx[i], rx[i]);
        end
    endtask

    // One data byte only; a read ends with a master refusal
    task automatic txn(input int b, input logic [6:0] a, input logic rw,
                       input logic [7:0] wd, output logic [7:0] rd,
                       output logic [1:0] ack);
        logic [7:0] junk;
        logic s;
        sda_o[b] = 1'h0;
        tick(HALF);
        scl_o[b] = 1'h0;
        byte_io(b, {a, rw}, junk);
        put_bit(b, 1'h1, s);
        ack[1] = ~s;
        byte_io(b, rw ? 8'hFF : wd, rd);
        put_bit(b, 1'h1, s);
        ack[0] = ~s;
        tick(4);
        sda_o[b] = 1'h0;
        tick(HALF);
        scl_o[b] = 1'h1;
        tick(HALF);
        sda_o[b] = 1'h1;
        tick(HALF);
    endtask

    task automatic ctrl_pair(input logic [7:0] v);
        logic [7:0] r;
        logic [1:0] k;
        ctrl_base = v;
        txn(1, bdio_pkg::DEV_ADDR, 1'h0, v, r, k);
        txn(1, bdio_pkg::DEV_ADDR, 1'h0, v | 8'h02, r, k);
    endtask

    task automatic preset(input logic [1:0] c);
        logic [7:0] r;
        logic [1:0] k;
        cfg = c;
        txn(0, bdio_pkg::DEV_ADDR, 1'h0,
            {~c[1], ~c[1], ~c[0], ~c[0], 4'h0}, r, k);
        if (c == 2'h0) begin
            txn(1, bdio_pkg::DEV_ADDR, 1'h0, 8'hF0, r, k);
        end else begin
            ctrl_pair({4'hF, c, 2'h0});
        end
    endtask

    // Input-group bits stay high so those pins are never sunk
    task automatic set_out(input logic [3:0] v);
        logic [7:0] r;
        logic [1:0] k;
        txn(0, bdio_pkg::DEV_ADDR, 1'h0,
            {v | ~{cfg[1], cfg[1], cfg[0], cfg[0]}, 4'h0}, r, k);
    endtask

    task automatic set_lines(input logic [3:0] v, input logic commit);
        host_line_o = v;
        if (commit) begin
            ctrl_pair(ctrl_base);
        end
    endtask
endmodule

`default_nettype wire

// [testbench/tb_board_digital_io_expander_port.sv]
`default_nettype none

module tb_board_digital_io_expander_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'h0;
    logic resetn_i = 1'h0;
    logic ce = 1'h1;
    logic [3:0] in_val = 4'hF;
    logic [3:0] in_conn = 4'h3;
    logic [3:0] cfg_ext = 4'h5;
    int failures = 0;
    int n_checks = 0;
    wire [1:0] scl;
    wire [1:0] hsda;
    wire [3:0] hline;
    logic pri_o, pri_oe_n, sec_o, sec_oe_n, alert_o, alert_oe_n;
    logic [3:0] pd, cfg_o, cfg_oe_n, out_o, out_oe_n;
    // ------------------------------------------------
    // Pads: pulled-up bus, pulled-down inputs
    // ------------------------------------------------
    wire [1:0] sda_w = {hsda[1] & (sec_oe_n | sec_o),
                        hsda[0] & (pri_oe_n | pri_o)};
    wire [3:0] in_lvl = (in_val & in_conn) | (~in_conn & ~pd);
    wire [3:0] cfg_lvl = cfg_ext & (cfg_oe_n | cfg_o);

    always #20 clock_i = ~clock_i;

    bdio_port_top i_dut (
        .clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce),
        .pri_scl_i(scl[0]), .pri_sda_i(sda_w[0]), .pri_sda_o(pri_o),
        .pri_sda_oe_n_o(pri_oe_n), .sec_scl_i(scl[1]),
        .sec_sda_i(sda_w[1]), .sec_sda_o(sec_o), .sec_sda_oe_n_o(sec_oe_n),
        .input_pin_i(in_lvl), .input_pulldown_o(pd),
        .config_pin_i(cfg_lvl), .config_pin_o(cfg_o),
        .config_pin_oe_n_o(cfg_oe_n), .host_line_i(hline),
        .output_pin_o(out_o), .output_pin_oe_n_o(out_oe_n),
        .alert_o(alert_o), .alert_oe_n_o(alert_oe_n)
    );

    bdio_host i_host (
        .clock_i(clock_i), .sda_i(sda_w), .scl_o(scl), .sda_o(hsda),
        .host_line_o(hline)
    );

    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic rd(input int b, input logic [7:0] exp);
        logic [7:0] r;
        logic [1:0] k;
        i_host.txn(b, bdio_pkg::DEV_ADDR, 1'h1, 8'h00, r, k);
        chk({7'h0, k[1]}, 8'h01, "read address ack");
        chk(r, exp, "read data");
    endtask

    task automatic wr(input int b, input logic [7:0] d);
        logic [7:0] r;
        logic [1:0] k;
        i_host.txn(b, bdio_pkg::DEV_ADDR, 1'h0, d, r, k);
        chk({6'h0, k}, 8'h03, "write acks");
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        logic [7:0] r;
        logic [1:0] k;
        logic [3:0] grp;
        logic [3:0] exp_oe;
        repeat (6) @(negedge clock_i);
        resetn_i = 1'h1;
        chk({cfg_oe_n, out_oe_n}, 8'hFF, "released after reset");
        i_host.tick(6);
        rd(0, 8'h53);
        i_host.txn(0, 7'h21, 1'h1, 8'h00, r, k);
        chk({7'h0, k[1]}, 8'h00, "foreign address");
        chk({7'h0, alert_oe_n}, 8'h01, "alert idle");
        in_conn = 4'hF;
        i_host.tick(12);
        chk({7'h0, alert_oe_n}, 8'h00, "alert raised");
        rd(0, 8'h5F);
        i_host.tick(2);
        chk({7'h0, alert_oe_n}, 8'h01, "alert cleared");
        in_val = 4'h6;
        i_host.tick(12);
        chk({7'h0, alert_oe_n}, 8'h00, "alert on input");
        rd(0, 8'h56);
        // Enable low: a config pin change must not reach the alert
        ce = 1'h0;
        cfg_ext = 4'hF;
        i_host.tick(6);
        chk({7'h0, alert_oe_n}, 8'h01, "frozen by enable");
        ce = 1'h1;
        i_host.tick(12);
        chk({7'h0, alert_oe_n}, 8'h00, "alert on config pin");
        rd(0, 8'hF6);
        // Every direction preset, one pin of each output group sunk
        for (int c = 0; c < 4; c++) begin
            i_host.preset(c[1:0]);
            i_host.set_out(4'hA);
            grp = {c[1], c[1], c[0], c[0]};
            exp_oe = ~(grp & 4'h5);
            i_host.tick(2);
            chk({4'h0, cfg_oe_n}, {4'h0, exp_oe}, "pin sink");
            rd(0, {cfg_ext & exp_oe, in_val});
        end
        // Strobe already high: direction must not move
        wr(1, 8'hF6);
        i_host.tick(2);
        chk({4'h0, cfg_oe_n}, 8'h0A, "no strobe rise");
        wr(1, 8'hF4);
        wr(1, 8'hF6);
        i_host.tick(2);
        chk({4'h0, cfg_oe_n}, 8'h0E, "strobe rise");
        i_host.set_lines(4'h3, 1'h1);
        i_host.tick(2);
        chk({4'h0, out_oe_n}, 8'h0C, "lines a b");
        i_host.set_lines(4'h8, 1'h0);
        i_host.tick(20);
        chk({4'h0, out_oe_n}, 8'h0C, "held without commit");
        i_host.set_lines(4'h8, 1'h1);
        i_host.tick(2);
        chk({4'h0, out_oe_n}, 8'h07, "line d");
        chk({4'h0, out_o}, 8'h00, "outputs only sink");
        rd(1, 8'hFE);
        give_verdict();
    end

    initial begin
        repeat (100000) @(posedge clock_i);
        failures++;
        $display("MISMATCH %0t run did not finish", $time);
        give_verdict();
    end
endmodule

`default_nettype wire
